// ==== hw/sft_pkg.sv ====
// Purpose: shared constants for the serial frame transmitter
// Assumes: APB with 32-bit data, one register per aligned word except 0x0C, shared by format and baud divisor high
// Notes: register values occupy the low byte, upper bits read as zero
package sft_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_DATA = 8'h00; // serial_data_port
	localparam logic [7:0] ADDR_CSA = 8'h04; // ctrl_status_a
	localparam logic [7:0] ADDR_CSB = 8'h08; // ctrl_status_b
	localparam logic [7:0] ADDR_FMT = 8'h0C; // frame_format_reg / baud_divisor_high
	localparam logic [7:0] ADDR_BDL = 8'h10; // baud_divisor_low
	// ctrl_status_a fields
	localparam int CSA_DONE = 6; // tx_done_flag, write one clears
	localparam int CSA_EMPTY = 5; // tx_buffer_empty_flag, read only
	localparam int CSA_DSPEED = 1; // double_speed
	localparam int CSA_MASTER = 0; // sync clock master select
	// ctrl_status_b fields
	localparam int CSB_DONE_IE = 6; // tx_done_irq_enable
	localparam int CSB_EMPTY_IE = 5; // buffer_empty_irq_enable
	localparam int CSB_TRANSMIT_ENABLE = 3; // transmit_enable
	localparam int CSB_SIZE2 = 2; // char_size_code bit 2
	localparam int CSB_NINTH = 0; // tx_ninth_bit
	// frame_format_reg fields
	localparam int FMT_SELECT = 7; // format_reg_select
	localparam int FMT_SYNC = 6; // synchronous mode
	localparam int FMT_PAR_EN = 5; // parity_enable_bit
	localparam int FMT_PAR_ODD = 4; // odd parity
	localparam int FMT_STOP2 = 3; // stop_bit_select
	localparam int FMT_SIZE1 = 2; // char_size_code bit 1
	localparam int FMT_SIZE0 = 1; // char_size_code bit 0
	localparam int FMT_POL = 0; // sync_clock_polarity
	// reset values
	localparam logic [2:0] RST_SIZE = 3'h3; // eight data bits
	localparam logic [11:0] RST_DIVISOR = 12'h000;
	// prescale counts per bit
	localparam logic [3:0] PRE_NORMAL = 4'hF; // divide by 16
	localparam logic [3:0] PRE_DOUBLE = 4'h7; // divide by 8
	localparam logic [3:0] PRE_SYNC = 4'h1; // divide by 2
	// frame geometry
	localparam int FRAME_W = 13; // start, nine data, parity, two stops
	localparam logic [3:0] SIZE_NINE = 4'h9;
	localparam logic [3:0] SIZE_EIGHT = 4'h8;
	localparam logic [3:0] SIZE_BASE = 4'h5;
	localparam logic [2:0] CODE_NINE = 3'h7;
	// transmitter states
	typedef enum logic {SFT_IDLE, SFT_SEND} sft_state_type;
endpackage

// ==== hw/sft_serial_frame_transmitter.sv ====
// Purpose: transmit half of a serial frame transceiver behind an APB slave
// Assumes: ref_clk at 250 MHz, rst asynchronous active high
// Notes: one pending character is buffered; answers come one cycle into access
`timescale 1ns/10ps
`default_nettype none
module sft_serial_frame_transmitter
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt requests and service
	input wire logic globalIrqEnable,
	input wire logic txDoneIrqAck,
	output logic bufEmptyIrq,
	output logic txDoneIrq,
	// serial pin
	output logic txdOut,
	output logic txdOe,
	// synchronous clock pin
	input wire logic extSyncClockIn,
	output logic extSyncClockOut,
	output logic extSyncClockOe
);
	import sft_pkg::*;

	// configuration registers
	logic doubleSpeed_q, clkMaster_q, doneFlag_q;
	logic bufIe_q, doneIe_q, txEnBit_q, size2_q, ninth_q;
	logic sync_q, parEn_q, parOdd_q, stop2_q, pol_q;
	logic [1:0] size_q;
	logic [11:0] divisor_q;
	// transmit buffer and shifter
	logic [8:0] bufData_q; // one character plus ninth bit
	logic bufFull_q;
	logic [FRAME_W-1:0] shift_q;
	logic [3:0] remain_q; // bits still to send after current one
	sft_state_type state_q;
	logic txEnActive_q; // transmitter really owns the pin
	logic txLine_q;
	// clocking
	logic [11:0] baudCnt_q;
	logic [3:0] preCnt_q;
	logic xck_q;
	logic xs1_q, xs2_q, xs3_q; // external clock synchroniser and edge stage
	// bus
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic bufIrq_q, doneIrq_q;
	// combinational
	logic access, wrEn, mapped;
	logic wrData, wrCsa, wrCsb, wrFmt, wrBdh, wrBdl;
	logic baudTick, bitTick, loadNow, frameEnd;
	logic [2:0] sizeCode;
	logic [3:0] dataBits, frameLen, preLimit;
	logic [FRAME_W-1:0] frameD;
	logic [31:0] readD;

	// bus decode; a write commits only at the edge where pready is seen high
	assign access = psel && penable;
	assign wrEn = access && pready_q && pwrite;
	assign wrData = wrEn && paddr == ADDR_DATA;
	assign wrCsa = wrEn && paddr == ADDR_CSA;
	assign wrCsb = wrEn && paddr == ADDR_CSB;
	assign wrFmt = wrEn && paddr == ADDR_FMT && pwdata[FMT_SELECT];
	assign wrBdh = wrEn && paddr == ADDR_FMT && !pwdata[FMT_SELECT];
	assign wrBdl = wrEn && paddr == ADDR_BDL;
	assign mapped = paddr == ADDR_DATA || paddr == ADDR_CSA || paddr == ADDR_CSB
		|| paddr == ADDR_FMT || paddr == ADDR_BDL;

	// read mux; the data location reads zero since no receiver sits here
	always_comb
	begin
		readD = 32'h0000_0000;
		unique case (paddr)
			ADDR_CSA:
			begin
				readD[CSA_DONE] = doneFlag_q;
				readD[CSA_EMPTY] = !bufFull_q;
				readD[CSA_DSPEED] = doubleSpeed_q;
				readD[CSA_MASTER] = clkMaster_q;
			end
			ADDR_CSB:
			begin
				readD[CSB_DONE_IE] = doneIe_q;
				readD[CSB_EMPTY_IE] = bufIe_q;
				readD[CSB_TRANSMIT_ENABLE] = txEnBit_q;
				readD[CSB_SIZE2] = size2_q;
				readD[CSB_NINTH] = ninth_q;
			end
			ADDR_FMT:
			begin
				// shared location reads back the format side
				readD[FMT_SELECT] = 1'b1;
				readD[FMT_SYNC] = sync_q;
				readD[FMT_PAR_EN] = parEn_q;
				readD[FMT_PAR_ODD] = parOdd_q;
				readD[FMT_STOP2] = stop2_q;
				readD[FMT_SIZE1] = size_q[1];
				readD[FMT_SIZE0] = size_q[0];
				readD[FMT_POL] = pol_q;
			end
			ADDR_BDL: readD[7:0] = divisor_q[7:0];
			default: readD = 32'h0000_0000;
		endcase
	end

	// apb answer: one wait state, so every bus output is a flip-flop
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= access && !pready_q;
			pslverr_q <= access && !pready_q && !mapped;
			if (access && !pready_q && !pwrite)
				prdata_q <= readD;
		end
	end

	// control and format registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			doubleSpeed_q <= 1'b0;
			clkMaster_q <= 1'b0;
			bufIe_q <= 1'b0;
			doneIe_q <= 1'b0;
			txEnBit_q <= 1'b0;
			size2_q <= 1'b0;
			ninth_q <= 1'b0;
			sync_q <= 1'b0;
			parEn_q <= 1'b0;
			parOdd_q <= 1'b0;
			stop2_q <= 1'b0;
			size_q <= RST_SIZE[1:0];
			pol_q <= 1'b0;
			divisor_q <= RST_DIVISOR;
		end
		else
		begin
			// empty flag position is read only, a written value is dropped
			if (wrCsa)
			begin
				doubleSpeed_q <= pwdata[CSA_DSPEED];
				clkMaster_q <= pwdata[CSA_MASTER];
			end
			if (wrCsb)
			begin
				doneIe_q <= pwdata[CSB_DONE_IE];
				bufIe_q <= pwdata[CSB_EMPTY_IE];
				txEnBit_q <= pwdata[CSB_TRANSMIT_ENABLE];
				size2_q <= pwdata[CSB_SIZE2];
				ninth_q <= pwdata[CSB_NINTH];
			end
			if (wrFmt)
			begin
				sync_q <= pwdata[FMT_SYNC];
				parEn_q <= pwdata[FMT_PAR_EN];
				parOdd_q <= pwdata[FMT_PAR_ODD];
				stop2_q <= pwdata[FMT_STOP2];
				size_q <= pwdata[FMT_SIZE1:FMT_SIZE0];
				pol_q <= pwdata[FMT_POL];
			end
			if (wrBdh)
				divisor_q[11:8] <= pwdata[3:0];
			if (wrBdl)
				divisor_q[7:0] <= pwdata[7:0];
		end
	end

	// baud generator: reloads at zero or on a low divisor write
	assign baudTick = baudCnt_q == 12'h000;
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			baudCnt_q <= RST_DIVISOR;
		else if (wrBdl || baudTick)
			baudCnt_q <= wrBdl ? {divisor_q[11:8], pwdata[7:0]} : divisor_q;
		else
			baudCnt_q <= baudCnt_q - 12'h001;
	end

	// prescaler: 16 normal, 8 double speed, 2 in sync mode
	assign preLimit = sync_q ? PRE_SYNC : (doubleSpeed_q ? PRE_DOUBLE : PRE_NORMAL);
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			preCnt_q <= 4'h0;
		else if (baudTick)
			preCnt_q <= (preCnt_q >= preLimit) ? 4'h0 : preCnt_q + 4'h1;
	end

	// sync master clock: toggles each baud tick, only driven in sync master
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			xck_q <= 1'b0;
		else if (sync_q && clkMaster_q && baudTick)
			xck_q <= !xck_q;
	end

	// external clock: two flops to synchronise, a third for edge detection
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			xs1_q <= 1'b0;
			xs2_q <= 1'b0;
			xs3_q <= 1'b0;
		end
		else
		begin
			xs1_q <= extSyncClockIn;
			xs2_q <= xs1_q;
			xs3_q <= xs2_q;
		end
	end

	// bit pacing per mode; sync data changes on the polarity-chosen edge
	always_comb
	begin
		if (!sync_q)
			bitTick = baudTick && preCnt_q >= preLimit;
		else if (clkMaster_q)
			bitTick = baudTick && xck_q == pol_q;
		else
			bitTick = pol_q ? (xs3_q && !xs2_q) : (xs2_q && !xs3_q);
	end

	// frame assembly: masked data, parity before stops, ones elsewhere
	assign sizeCode = {size2_q, size_q};
	assign dataBits = (sizeCode == CODE_NINE) ? SIZE_NINE
		: (sizeCode[2] ? SIZE_EIGHT : SIZE_BASE + {2'b00, sizeCode[1:0]});
	assign frameLen = 4'h1 + dataBits + {3'b000, parEn_q} + (stop2_q ? 4'h2 : 4'h1);
	always_comb
	begin
		logic par;
		par = parOdd_q;
		frameD = {FRAME_W{1'b1}};
		frameD[0] = 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			if (4'(i) < dataBits)
			begin
				frameD[i + 1] = bufData_q[i];
				par = par ^ bufData_q[i];
			end
		end
		if (parEn_q)
			frameD[dataBits + 4'h1] = par;
	end

	// buffer move happens at a bit boundary once the shifter is free
	assign frameEnd = bitTick && remain_q == 4'h0;
	assign loadNow = frameEnd && bufFull_q && txEnActive_q;

	// transmit buffer: one entry, written by software, drained by the shifter
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			bufFull_q <= 1'b0;
			bufData_q <= 9'h000;
		end
		else if (wrData)
		begin
			// a write while full overwrites the waiting character
			bufFull_q <= 1'b1;
			bufData_q <= {ninth_q, pwdata[7:0]};
		end
		else if (loadNow)
			bufFull_q <= 1'b0;
	end

	// shifter: start bit goes out at the load, then one bit per bit tick
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= SFT_IDLE;
			shift_q <= {FRAME_W{1'b1}};
			remain_q <= 4'h0;
			txLine_q <= 1'b1;
		end
		else if (loadNow)
		begin
			state_q <= SFT_SEND;
			txLine_q <= frameD[0];
			shift_q <= {1'b1, frameD[FRAME_W-1:1]};
			remain_q <= frameLen - 4'h1;
		end
		else if (bitTick)
		begin
			unique case (state_q)
				SFT_IDLE: txLine_q <= 1'b1; // idle line is high
				SFT_SEND:
				begin
					if (remain_q != 4'h0)
					begin
						txLine_q <= shift_q[0];
						shift_q <= {1'b1, shift_q[FRAME_W-1:1]};
						remain_q <= remain_q - 4'h1;
					end
					else
					begin
						// last stop bit has run its full period
						state_q <= SFT_IDLE;
						txLine_q <= 1'b1;
					end
				end
			endcase
		end
	end

	// done flag: hardware set wins over ack and over write-one clear
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			doneFlag_q <= 1'b0;
		else if (frameEnd && state_q == SFT_SEND && !loadNow)
			doneFlag_q <= 1'b1;
		else if (txDoneIrqAck || (wrCsa && pwdata[CSA_DONE]))
			doneFlag_q <= 1'b0;
	end

	// enable takes hold at once, but release waits for all data to go
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			txEnActive_q <= 1'b0;
		else if (txEnBit_q)
			txEnActive_q <= 1'b1;
		else if (!bufFull_q && state_q == SFT_IDLE)
			txEnActive_q <= 1'b0;
	end

	// outputs registered; pin only owned while really enabled
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			txdOut <= 1'b1;
			txdOe <= 1'b0;
			extSyncClockOut <= 1'b0;
			extSyncClockOe <= 1'b0;
			bufIrq_q <= 1'b0;
			doneIrq_q <= 1'b0;
		end
		else
		begin
			txdOut <= txLine_q;
			txdOe <= txEnActive_q;
			extSyncClockOut <= xck_q;
			extSyncClockOe <= txEnActive_q && sync_q && clkMaster_q;
			bufIrq_q <= bufIe_q && globalIrqEnable && !bufFull_q;
			doneIrq_q <= doneIe_q && globalIrqEnable && doneFlag_q && !txDoneIrqAck;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign bufEmptyIrq = bufIrq_q;
	assign txDoneIrq = doneIrq_q;

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_wr_fills;
		wrData |=> bufFull_q ##1 !bufEmptyIrq;
	endproperty
	a_wr_fills: assert property (p_wr_fills) else $error("data write left buffer empty");
	property p_empty_irq;
		(bufIe_q && globalIrqEnable && !bufFull_q) |=> bufEmptyIrq;
	endproperty
	a_empty_irq: assert property (p_empty_irq) else $error("empty interrupt missing");
	property p_done_set;
		(frameEnd && state_q == SFT_SEND && !bufFull_q) |=> doneFlag_q && state_q == SFT_IDLE;
	endproperty
	a_done_set: assert property (p_done_set) else $error("done flag not set");
	property p_done_clr;
		(doneFlag_q && txDoneIrqAck && !frameEnd) |=> !doneFlag_q;
	endproperty
	a_done_clr: assert property (p_done_clr) else $error("done flag not cleared");
	property p_disable_wait;
		(txEnActive_q && !txEnBit_q && (bufFull_q || state_q == SFT_SEND)) |=> txEnActive_q;
	endproperty
	a_disable_wait: assert property (p_disable_wait) else $error("disabled with data");
	property p_start_low;
		loadNow |=> !txLine_q ##1 !txdOut;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low");
	property p_idle_high;
		(state_q == SFT_IDLE) |-> txLine_q;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("idle line low");
	property p_baud_reload;
		(baudTick && !wrBdl) |=> baudCnt_q == $past(divisor_q);
	endproperty
	a_baud_reload: assert property (p_baud_reload) else $error("baud counter reload wrong");
	property p_pin_release;
		!txEnActive_q |=> !txdOe;
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("pin still driven");

	c_load: cover property (loadNow);
	c_done: cover property (frameEnd && state_q == SFT_SEND && !bufFull_q);
	c_disable: cover property ($fell(txEnActive_q));
	c_slave_tick: cover property (sync_q && !clkMaster_q && bitTick);
endmodule
`default_nettype wire

// ==== sim/sft_peer_model.sv ====
// Purpose: remote serial peer listening on the transmit line
// Assumes: bit period given in system clocks by the bench
// Notes: line is pulled up whenever the pin is released
`timescale 1ns/10ps
`default_nettype none
module sft_peer_model
(
	// clock and line
	input wire logic ref_clk,
	input wire logic txdOut,
	input wire logic txdOe,
	// frame geometry
	input wire logic [15:0] bitClocks,
	input wire logic [3:0] frameLen,
	// captured frames, bits in wire order
	output logic [12:0] frameBits,
	output logic [7:0] nFrames
);
	logic line; // level the peer really sees
	logic [12:0] bits; // frame being gathered
	// released pin floats to the pull-up, never to the last driven value
	assign line = txdOe ? txdOut : 1'b1;
	// hunt for a start bit, then sample every bit in its middle
	initial
	begin
		nFrames = 8'h00;
		frameBits = 13'h0000;
		forever
		begin
			@(posedge ref_clk);
			if (line === 1'b0)
			begin
				bits = 13'h0000;
				repeat (bitClocks / 2) @(posedge ref_clk);
				for (int i = 0; i < frameLen; i++)
				begin
					bits[i] = line;
					if (i < frameLen - 1)
						repeat (bitClocks) @(posedge ref_clk);
				end
				// bits first, count last, so a reader never sees a stale frame
				frameBits = bits;
				nFrames = nFrames + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: self-checking bench for the serial frame transmitter
// Assumes: APB master here, peer model on the transmit line
// Notes: expected frames are built from the format settings and written characters alone
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import sft_pkg::*;
	logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, err, xckPrev, slaveRun;
	logic [7:0] paddr, nFrames;
	logic [31:0] pwdata, prdata, rd;
	logic globalIrqEnable, txDoneIrqAck, bufEmptyIrq, txDoneIrq, txdOut, txdOe;
	logic extSyncClockIn, extSyncClockOut, extSyncClockOe;
	logic [15:0] bitClocks;
	logic [3:0] frameLen;
	logic [12:0] frameBits;
	logic [12:0] expQ[$]; // frames the model expects, oldest first
	int n_mismatch, n_tests, seen, dv;
	sft_serial_frame_transmitter u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .globalIrqEnable(globalIrqEnable),
		.txDoneIrqAck(txDoneIrqAck), .bufEmptyIrq(bufEmptyIrq), .txDoneIrq(txDoneIrq),
		.txdOut(txdOut), .txdOe(txdOe), .extSyncClockIn(extSyncClockIn),
		.extSyncClockOut(extSyncClockOut), .extSyncClockOe(extSyncClockOe));
	sft_peer_model u_peer (.ref_clk(ref_clk), .txdOut(txdOut), .txdOe(txdOe),
		.bitClocks(bitClocks), .frameLen(frameLen), .frameBits(frameBits), .nFrames(nFrames));
	// 250 MHz system clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// far-end synchronous clock: toggles every four system clocks while enabled
	initial
	begin
		forever
		begin
			repeat (4) @(posedge ref_clk);
			extSyncClockIn <= slaveRun && !extSyncClockIn;
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// no fixed wait count; only the watchdog ends a missing answer
		do
		begin
			@(posedge ref_clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// wire-order frame: start, data lsb first, parity, stops
	function automatic logic [12:0] mkFrame(input int nb, par, odd, st2, input logic [8:0] v);
		logic [12:0] f;
		int j;
		logic p;
		f = 13'h0000;
		j = 1;
		p = odd[0];
		for (int i = 0; i < nb; i++)
		begin
			f[j] = v[i];
			p = p ^ v[i];
			j++;
		end
		if (par != 0)
		begin
			f[j] = p;
			j++;
		end
		f[j] = 1'b1;
		if (st2 != 0)
			f[j + 1] = 1'b1;
		return f;
	endfunction
	// wait for the next frame, bounded only by the watchdog, then compare with the model
	task automatic getFrame;
		while (nFrames == seen[7:0])
		begin
			@(posedge ref_clk);
		end
		seen++;
		chk({19'h0, frameBits}, {19'h0, expQ.pop_front()});
	endtask
	// two characters back to back in one frame format
	task automatic runFmt(input int code, par, odd, st2, dbl);
		int nb;
		logic [7:0] v;
		logic [8:0] f;
		nb = (code == 7) ? 9 : code + 5;
		bitClocks = 16'((dbl ? 8 : 16) * (dv + 1));
		frameLen = 4'(nb + 2 + par + st2);
		apb(1'b1, ADDR_CSA, 32'(dbl << CSA_DSPEED));
		apb(1'b1, ADDR_FMT, 32'(128 | par << 5 | odd << 4 | st2 << 3 | (code & 3) << 1));
		for (int k = 0; k < 2; k++)
		begin
			v = 8'($urandom);
			f = 9'($urandom);
			apb(1'b1, ADDR_CSB, 32'(8 | (code >> 2) << 2 | f[0]));
			expQ.push_back(mkFrame(nb, par, odd, st2, {f[0], v}));
			apb(1'b1, ADDR_DATA, ($urandom & 32'hFFFFFF00) | v);
			chk(32'(txdOe), 32'h1);
			if (k == 1)
				rdChk(ADDR_CSA, 32'(dbl << 1));
			// poll until the first character has left the buffer; the watchdog bounds it
			rd = 32'h0;
			while (k == 0 && rd[CSA_EMPTY] !== 1'b1)
				apb(1'b0, ADDR_CSA, 32'h0);
		end
		getFrame();
		getFrame();
		repeat (bitClocks) @(posedge ref_clk);
		rdChk(ADDR_CSA, 32'(96 | dbl << 1));
		apb(1'b1, ADDR_CSA, 32'(64 | dbl << 1));
		rdChk(ADDR_CSA, 32'(32 | dbl << 1));
	endtask
	initial
	begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{globalIrqEnable, txDoneIrqAck, extSyncClockIn, slaveRun, seen, dv} = 0;
		{n_mismatch, n_tests, bitClocks, frameLen} = {64'h0, 16'h10, 4'hA};
		void'($urandom(32'h2BA2E0EE));
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		rdChk(ADDR_CSA, 32'h20);
		rdChk(ADDR_FMT, 32'h86);
		apb(1'b0, 8'h14, 32'h0);
		chk(32'(err), 32'h1);
		chk(32'(txdOe), 32'h0);
		$display("test reset done");
		for (int c = 0; c < 5; c++)
			for (int p = 0; p < 3; p++)
				for (int s = 0; s < 2; s++)
					runFmt(c == 4 ? 7 : c, p > 0, p == 2, s, (c + p + s) % 2);
		dv = 1;
		apb(1'b1, ADDR_BDL, 32'h1);
		runFmt(3, 1, 1, 0, 0);
		$display("test formats done");
		globalIrqEnable <= 1'b1;
		apb(1'b1, ADDR_CSB, 32'h68);
		// enable lands at the commit edge, the request one register later
		repeat (2) @(posedge ref_clk);
		chk(32'(bufEmptyIrq), 32'h1);
		expQ.push_back(mkFrame(8, 1, 1, 0, 9'h05A));
		apb(1'b1, ADDR_DATA, 32'h5A);
		getFrame();
		repeat (bitClocks) @(posedge ref_clk);
		chk(32'(txDoneIrq), 32'h1);
		txDoneIrqAck <= 1'b1;
		@(posedge ref_clk);
		txDoneIrqAck <= 1'b0;
		rdChk(ADDR_CSA, 32'h20);
		$display("test interrupts done");
		expQ.push_back(mkFrame(8, 1, 1, 0, 9'h0C3));
		apb(1'b1, ADDR_DATA, 32'hC3);
		apb(1'b1, ADDR_CSB, 32'h0);
		chk(32'(txdOe), 32'h1);
		getFrame();
		repeat (bitClocks * 2) @(posedge ref_clk);
		chk(32'(txdOe), 32'h0);
		$display("test disable done");
		// synchronous master at divisor one, then slave on the far-end clock
		bitClocks = 16'h4;
		frameLen = 4'hA;
		apb(1'b1, ADDR_CSA, 32'h1);
		apb(1'b1, ADDR_FMT, 32'hC6);
		apb(1'b1, ADDR_CSB, 32'h8);
		expQ.push_back(mkFrame(8, 0, 0, 0, 9'h0A5));
		apb(1'b1, ADDR_DATA, 32'hA5);
		chk(32'(extSyncClockOe), 32'h1);
		xckPrev = extSyncClockOut;
		repeat (2) @(posedge ref_clk);
		chk(32'(extSyncClockOut), 32'(!xckPrev));
		getFrame();
		repeat (bitClocks) @(posedge ref_clk);
		bitClocks = 16'h8;
		slaveRun <= 1'b1;
		apb(1'b1, ADDR_CSA, 32'h0);
		expQ.push_back(mkFrame(8, 0, 0, 0, 9'h03C));
		apb(1'b1, ADDR_DATA, 32'h3C);
		chk(32'(extSyncClockOe), 32'h0);
		getFrame();
		slaveRun <= 1'b0;
		$display("test sync done");
		tally_and_finish();
	end
	// hang guard, well past the expected run length
	initial
	begin
		repeat (99000) @(posedge ref_clk);
		n_mismatch++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule
`default_nettype wire
